//--- design/sram_host_consts.svh
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
// ----------------------------------------
// geometry
// ----------------------------------------
`define IDX_W           12
`define CELL_COUNT      4096
// ----------------------------------------
// timing (10 mhz core clock, 100 ns period)
// ----------------------------------------
`define CLK_PERIOD_NS   100
`define CYCLE_TIME_NS   450
`define CYCLE_CLKS      ((`CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WPULSE_NS       200
`define WPULSE_CLKS     ((`WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYCLES  5
`define RECOVER_CLKS    (`RECOVER_CYCLES * `CYCLE_CLKS)
`define SYNC_LAT_CLKS   3
`endif

//--- design/sram_host_pkg.sv
package sram_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_READ  = 3'b100,
    ST_SLEEP = 3'b101,
    ST_WAKE  = 3'b110
  } state_t;

  typedef struct packed {
    logic [11:0] cell_index;
    logic        sel_n;
    logic        store_n;
    logic        din;
  } pins_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] cell_index;
    logic        wdata;
  } req_t;
endpackage : sram_host_pkg

//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; level accepted when stages two and three agree
module pin_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin,
  output var  logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.s1  = pin;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule : pin_sync
`default_nettype wire

//--- design/sram_host.sv
// Contract
// R01 - device decodes twelve-bit cell index to one of 4096 one-bit cells
// R02 - host holds cell index steady for the whole write access
// R03 - deselected device ignores input and floats output; selected enables both
// R04 - selected device reads with store enable high, writes with it low
// R05 - host keeps store enable high whenever cell index changes
// R06 - selected device with store enable low stores the input bit
// R07 - output floats when deselected or writing, so pins can share wire
// R08 - read data has the polarity it was written with
// R09 - chip enable may stay low; read data stays valid during read
// R10 - before and during standby host holds chip and store enables high
// R11 - no access during standby; device keeps its contents
// R12 - after standby host waits five cycle times before normal use
// R13 - a read returns the value last written to that cell
`timescale 1ns/1ps
`include "sram_host_consts.svh"
`default_nettype none
module sram_host #(
  parameter int IDX_W       = `IDX_W,
  parameter int CYCLE_CLKS  = `CYCLE_CLKS,
  parameter int WPULSE_CLKS = `WPULSE_CLKS,
  parameter int RECOV_CLKS  = `RECOVER_CLKS
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire sram_host_pkg::req_t   req,
  output var  logic                  req_ready,
  output var  logic                  rd_valid,
  output var  logic                  rd_data,
  input  wire logic                  standby_req,
  output var  logic                  standby_ok,
  output var  sram_host_pkg::pins_t  pins,
  input  wire logic                  dout_pin
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sram_host_pkg::state_t st;
    logic [15:0]           cnt;
    sram_host_pkg::pins_t  pins;
    logic                  rdy;
    logic                  rvld;
    logic                  rdat;
    logic                  sok;
  } host_t;

  host_t s_q;
  host_t s_d;
  logic  dout_lvl;
  // read waits out the access time, then the three synchroniser stages
  localparam int SYNC_CLKS = `SYNC_LAT_CLKS;

  // off-chip output passes the three-stage synchroniser
  pin_sync u_dout_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin      (dout_pin),
    .level    (dout_lvl)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.rvld = 1'b0;
    if (s_q.cnt != 16'h0000) begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end
    unique case (s_q.st)
      sram_host_pkg::ST_IDLE: begin
        s_d.pins.store_n = 1'b1;
        s_d.pins.sel_n   = 1'b1;
        if (standby_req) begin
          // both enables held high through standby
          s_d.st  = sram_host_pkg::ST_SLEEP; // R10
          s_d.rdy = 1'b0;
          s_d.sok = 1'b1;
        end else if (req.valid) begin
          // index changes only while store enable is high
          s_d.pins.cell_index = req.cell_index[11:0]; // R05
          s_d.pins.din        = req.wdata;
          s_d.pins.sel_n      = 1'b0;
          s_d.rdy             = 1'b0;
          s_d.cnt             = 16'(CYCLE_CLKS + SYNC_CLKS);
          s_d.st = req.write ? sram_host_pkg::ST_SETUP : sram_host_pkg::ST_READ;
        end
      end
      sram_host_pkg::ST_SETUP: begin
        s_d.pins.store_n = 1'b0; // R04
        s_d.cnt          = 16'(WPULSE_CLKS);
        s_d.st           = sram_host_pkg::ST_WRITE;
      end
      sram_host_pkg::ST_WRITE: begin
        // index and data stay put until the strobe rises
        if (s_q.cnt <= 16'h0001) begin // R02
          s_d.pins.store_n = 1'b1;
          s_d.st           = sram_host_pkg::ST_HOLD;
        end
      end
      sram_host_pkg::ST_HOLD: begin
        s_d.pins.sel_n = 1'b1;
        s_d.rdy        = 1'b1;
        s_d.st         = sram_host_pkg::ST_IDLE;
      end
      sram_host_pkg::ST_READ: begin
        // sample once access time plus synchroniser delay have elapsed
        if (s_q.cnt == 16'h0000) begin // R09
          s_d.rdat       = dout_lvl; // R08
          s_d.rvld       = 1'b1;
          s_d.pins.sel_n = 1'b1;
          s_d.rdy        = 1'b1;
          s_d.st         = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_SLEEP: begin
        s_d.pins.sel_n   = 1'b1; // R11
        s_d.pins.store_n = 1'b1;
        if (!standby_req) begin
          s_d.cnt = 16'(RECOV_CLKS);
          s_d.st  = sram_host_pkg::ST_WAKE;
        end
      end
      sram_host_pkg::ST_WAKE: begin
        // no access until recovery time has passed
        if (s_q.cnt <= 16'h0001) begin // R12
          s_d.sok = 1'b0;
          s_d.rdy = 1'b1;
          s_d.st  = sram_host_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.st = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q              <= '0;
      s_q.st           <= sram_host_pkg::ST_IDLE;
      s_q.pins.sel_n   <= 1'b1;
      s_q.pins.store_n <= 1'b1;
      s_q.rdy          <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins       = s_q.pins;
  assign req_ready  = s_q.rdy;
  assign rd_valid   = s_q.rvld;
  assign rd_data    = s_q.rdat;
  assign standby_ok = s_q.sok;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_INDEX_STABLE_WRITE: assert property (@(posedge core_clk) disable iff (rst) // R02
    !s_q.pins.store_n |=> $stable(s_q.pins.cell_index) || $past(s_q.pins.store_n))
    else $error("cell index moved during write");
  AST_STROBE_HIGH_ON_CHANGE: assert property (@(posedge core_clk) disable iff (rst) // R05
    !$stable(s_q.pins.cell_index) |-> s_q.pins.store_n && $past(s_q.pins.store_n))
    else $error("cell index changed with store enable low");
  AST_WRITE_SELECTED: assert property (@(posedge core_clk) disable iff (rst) // R04
    !s_q.pins.store_n |-> !s_q.pins.sel_n)
    else $error("store strobe without chip enable");
  AST_STANDBY_QUIET: assert property (@(posedge core_clk) disable iff (rst) // R10
    s_q.st == sram_host_pkg::ST_SLEEP |-> s_q.pins.sel_n && s_q.pins.store_n)
    else $error("enable low during standby");
  AST_NO_ACCESS_STANDBY: assert property (@(posedge core_clk) disable iff (rst) // R11
    s_q.sok |-> !s_q.rdy && s_q.pins.sel_n)
    else $error("access offered during standby");
  AST_RECOVERY_WAIT: assert property (@(posedge core_clk) disable iff (rst) // R12
    $rose(s_q.st == sram_host_pkg::ST_WAKE) |-> !s_q.rdy [*5])
    else $error("ready too soon after standby");
  AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (rst) // R09
    $rose(s_q.st == sram_host_pkg::ST_READ) |-> ##[1:40] s_q.rvld)
    else $error("read answer missing");

  // ----------------------------------------
  // sequencing checks
  // ----------------------------------------
  AST_STROBE_IN_WRITE: assert property (@(posedge core_clk) disable iff (rst) // R05
    !s_q.pins.store_n |-> s_q.st == sram_host_pkg::ST_WRITE)
    else $error("store strobe low outside write state");
  AST_SETUP_SELECTED: assert property (@(posedge core_clk) disable iff (rst) // R05
    s_q.st == sram_host_pkg::ST_SETUP |-> !s_q.pins.sel_n && s_q.pins.store_n)
    else $error("setup cycle without select or with strobe low");
  AST_INDEX_ONLY_ON_TAKE: assert property (@(posedge core_clk) disable iff (rst) // R05
    !$stable(s_q.pins.cell_index) |-> $past(s_q.st == sram_host_pkg::ST_IDLE))
    else $error("cell index changed outside request take");
  AST_WRITE_PULSE: assert property (@(posedge core_clk) disable iff (rst) // R02
    $fell(s_q.pins.store_n) |-> (!s_q.pins.store_n) [*2] ##1 s_q.pins.store_n)
    else $error("write strobe width wrong");
  AST_DESELECT_AFTER_WRITE: assert property (@(posedge core_clk) disable iff (rst) // R02
    $rose(s_q.pins.store_n) |=> s_q.pins.sel_n)
    else $error("select not released after write");
  AST_READ_HELD: assert property (@(posedge core_clk) disable iff (rst) // R09
    s_q.st == sram_host_pkg::ST_READ |-> !s_q.pins.sel_n && s_q.pins.store_n && !s_q.rdy)
    else $error("read access not held");
  AST_READ_SAMPLE_TIME: assert property (@(posedge core_clk) disable iff (rst) // R09
    $rose(s_q.st == sram_host_pkg::ST_READ) |-> ##8 s_q.st == sram_host_pkg::ST_READ ##1 s_q.rvld)
    else $error("read sampled before access and sync delay");
  AST_READ_DONE: assert property (@(posedge core_clk) disable iff (rst) // R09
    s_q.rvld |-> s_q.pins.sel_n && s_q.rdy ##1 !s_q.rvld)
    else $error("read answer not a single pulse at release");
  AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (rst) // R10
    s_q.st == sram_host_pkg::ST_IDLE |-> s_q.pins.sel_n && s_q.pins.store_n)
    else $error("enable low while idle");
  AST_STANDBY_ENTRY: assert property (@(posedge core_clk) disable iff (rst) // R10
    s_q.st == sram_host_pkg::ST_IDLE && standby_req |=> s_q.st == sram_host_pkg::ST_SLEEP && s_q.sok)
    else $error("standby not entered from idle");
  AST_SLEEP_NO_READY: assert property (@(posedge core_clk) disable iff (rst) // R11
    s_q.st == sram_host_pkg::ST_SLEEP |-> !s_q.rdy && s_q.sok)
    else $error("ready offered while asleep");
  AST_WAKE_SPAN: assert property (@(posedge core_clk) disable iff (rst) // R12
    $rose(s_q.st == sram_host_pkg::ST_WAKE) |-> ##24 !s_q.rdy ##1 s_q.rdy)
    else $error("recovery span wrong");
endmodule : sram_host
`default_nettype wire

//--- verif/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// far-end static cell array, 4096 by 1
// ----
module sram_model (
  input  wire sram_host_pkg::pins_t pins,
  output var  logic                 dout
);
  // output settles this long after select or index changes (slowest grade)
  localparam int ACCESS_NS = 450;
  logic mem [4096];
  logic last_q = 1'b0;
  logic dout_v;
  // level-sensitive store while selected and store enable low
  always @* begin
    if (!pins.sel_n && !pins.store_n) mem[pins.cell_index] = pins.din;
  end
  // no pull-up: a floating output shows the inverse of its last value
  always @* begin
    if (!pins.sel_n && pins.store_n) begin
      dout_v = mem[pins.cell_index];
      last_q = dout_v;
    end else begin
      dout_v = ~last_q;
    end
  end
  // late output makes the host wait out access time and synchroniser
  always @(dout_v) dout <= #ACCESS_NS dout_v;
endmodule : sram_model
`default_nettype wire

//--- verif/sram_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_tb_top;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 standby_req = 1'b0;
  sram_host_pkg::req_t  req = '0;
  logic                 req_ready, rd_valid, rd_data, standby_ok, dout_pin;
  sram_host_pkg::pins_t pins;
  int                   miscompares = 0;
  int                   n_tests = 0;
  always #50 core_clk = ~core_clk;
  sram_host DUT (.core_clk(core_clk), .rst(rst), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .standby_req(standby_req),
    .standby_ok(standby_ok), .pins(pins), .dout_pin(dout_pin));
  sram_model far_end (.pins(pins), .dout(dout_pin));
  // ----
  // helpers
  // ----
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_ready;
    int i;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge core_clk);
    check_bit("req_ready", 1'b1, req_ready);
  endtask : wait_ready
  task automatic issue(input logic w, input logic [11:0] idx, input logic b);
    wait_ready();
    req = '{1'b1, w, idx, b};
    @(negedge core_clk);
    req.valid = 1'b0;
    @(negedge core_clk);
    check_bit("sel_n", 1'b0, pins.sel_n);
    check_bit("store_n", ~w, pins.store_n);
    check_bit("cell_index", 1'b1, pins.cell_index === idx);
    if (w) check_bit("din", b, pins.din);
  endtask : issue
  task automatic do_read(input logic [11:0] idx, input logic exp);
    int i;
    issue(1'b0, idx, 1'b0);
    for (i = 0; i < 20 && rd_valid !== 1'b1; i++) @(negedge core_clk);
    check_bit("rd_valid", 1'b1, rd_valid);
    check_bit("rd_data", exp, rd_data);
  endtask : do_read
  // ----
  // scenarios
  // ----
  task automatic t_idle;
    check_bit("idle sel_n", 1'b1, pins.sel_n);
    check_bit("idle store_n", 1'b1, pins.store_n);
  endtask : t_idle
  task automatic t_cells;
    logic [11:0] a [5] = '{12'h000, 12'h001, 12'h0ff, 12'h800, 12'hfff};
    int i;
    for (i = 0; i < 5; i++) issue(1'b1, a[i], i[0]);
    for (i = 0; i < 5; i++) do_read(a[i], i[0]);
    issue(1'b1, 12'h000, 1'b1);
    do_read(12'h000, 1'b1);
    do_read(12'h001, 1'b1);
  endtask : t_cells
  task automatic t_standby;
    int i;
    issue(1'b1, 12'h5a5, 1'b1);
    wait_ready();
    standby_req = 1'b1;
    // a request raised together with standby must be ignored
    req = '{1'b1, 1'b0, 12'h5a5, 1'b0};
    repeat (4) @(negedge core_clk);
    check_bit("standby_ok", 1'b1, standby_ok);
    check_bit("sleep sel_n", 1'b1, pins.sel_n);
    check_bit("sleep store_n", 1'b1, pins.store_n);
    check_bit("sleep ready", 1'b0, req_ready);
    req.valid = 1'b0;
    standby_req = 1'b0;
    for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge core_clk);
    check_bit("recovery ready", 1'b1, req_ready);
    check_bit("recovery span", 1'b1, i >= 25);
    check_bit("standby_ok off", 1'b0, standby_ok);
    do_read(12'h5a5, 1'b1);
  endtask : t_standby
  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_idle();
    t_cells();
    t_standby();
    report_and_stop();
  end
  // run needs about 150 cycles; cut off well beyond
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
endmodule : sram_host_tb_top
`default_nettype wire
